// ==== rtl/gate_scheduler.v ====
// time-aware egress gate scheduler with wishbone configuration port
`timescale 1ns/100ps
`include "gate_sched_map.vh"

module gate_scheduler (
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [11:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  input wire [39:0] queue_nonempty_i,
  output reg [39:0] gate_open_o,
  output wire [4:0] tx_valid_o,
  output wire [14:0] tx_queue_o
);

  // =====================================================================
  // configuration storage
  reg [`NUM_GATES-1:0] slot_gates [0:`SLOT_DEPTH-1];
  reg [`NUM_PORTS-1:0] slot_ports [0:`SLOT_DEPTH-1];
  reg [`DUR_W-1:0] slot_dur [0:`SLOT_DEPTH-1];
  reg [`SLOT_AW-1:0] cyc_start [0:`NUM_CYCLES-1];
  reg [`SLOT_AW-1:0] cyc_end [0:`NUM_CYCLES-1];
  reg [`CTRL_EN_W-1:0] cyc_en;
  reg [`SLOT_AW-1:0] slot_idx;
  reg [`CYC_AW-1:0] cyc_sel;

  // =====================================================================
  // per-cycle run state
  reg [`SLOT_AW-1:0] cur_slot [0:`NUM_CYCLES-1];
  reg [`DUR_W-1:0] remain [0:`NUM_CYCLES-1];
  reg [`NUM_CYCLES-1:0] running;
  reg [`NUM_CYCLES-1:0] fire;
  reg [`TICK_CNT_W-1:0] tick_cnt;
  reg tick;

  // =====================================================================
  // operating notes
  // - the tables have no reset; a cycle enabled over unloaded entries
  //   drives unknown gates, so load start, end and slots first
  // - slots of one cycle run by index from start to end, so a cycle
  //   owns a contiguous range; ranges of different cycles may overlap
  // - a duration of zero behaves as one tick, keeping the walk moving
  // - gates move one clock after the tick that starts a slot, because
  //   the firing flag is registered before the gate update reads it
  // - two cycles firing together: the higher cycle number wins on the
  //   ports both name; software keeps slot starts apart to avoid it
  // - clearing an enable bit stops the cycle at once; gates keep the
  //   last value, so a stop never closes a gate by itself
  // - the bus answers one clock after it takes a request and ignores
  //   stb while ack is high, so a held request is taken only once
  // - a read returns table contents as they stood before a write
  //   falling in the same clock
  // - unmapped addresses read zero and still get an ack, so a bad
  //   pointer never hangs the master

  wire bus_req;
  wire bus_wr;
  wire [`SLOT_AW-1:0] dur_wr_idx;
  integer c;
  integer p;

  // =====================================================================
  // address decode, write strobes and read mux signals
  wire hit_ctrl;
  wire hit_status;
  wire hit_slot_idx;
  wire hit_slot_data;
  wire hit_slot_dur;
  wire hit_cyc_sel;
  wire hit_cyc_start;
  wire hit_cyc_end;
  wire hit_gate;
  wire [11:0] gate_off;
  wire [2:0] gate_port;
  wire lane0;
  wire lanes01;
  wire wr_ctrl;
  wire wr_slot_idx;
  wire wr_cyc_sel;
  wire wr_slot_data;
  wire wr_slot_dur;
  wire wr_cyc_start;
  wire wr_cyc_end;
  reg [31:0] next_rdata;
  reg [7:0] gate_word;
  wire [`SLOT_AW-1:0] next_slot [0:`NUM_CYCLES-1];

  assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign bus_wr = bus_req & wb_we_i;
  assign dur_wr_idx = slot_idx;

  // one select per register; gate views need word alignment
  assign hit_ctrl = (wb_adr_i == `REG_CTRL);
  assign hit_status = (wb_adr_i == `REG_STATUS);
  assign hit_slot_idx = (wb_adr_i == `REG_SLOT_IDX);
  assign hit_slot_data = (wb_adr_i == `REG_SLOT_DATA);
  assign hit_slot_dur = (wb_adr_i == `REG_SLOT_DUR);
  assign hit_cyc_sel = (wb_adr_i == `REG_CYC_SEL);
  assign hit_cyc_start = (wb_adr_i == `REG_CYC_START);
  assign hit_cyc_end = (wb_adr_i == `REG_CYC_END);
  assign hit_gate = (wb_adr_i >= `REG_GATE_BASE) &&
    (wb_adr_i <= `REG_GATE_LAST) &&
    (wb_adr_i[1:0] == 2'h0);
  assign gate_off = wb_adr_i - `REG_GATE_BASE;
  assign gate_port = gate_off[4:2];

  // narrow registers need lane 0, wide ones lanes 0 and 1
  assign lane0 = wb_sel_i[0];
  assign lanes01 = (wb_sel_i[1:0] == 2'h3);

  // write strobes last exactly the taking clock
  assign wr_ctrl = bus_wr & hit_ctrl & lane0;
  assign wr_slot_idx = bus_wr & hit_slot_idx & lanes01;
  assign wr_cyc_sel = bus_wr & hit_cyc_sel & lane0;
  assign wr_slot_data = bus_wr & hit_slot_data & lanes01;
  assign wr_slot_dur = bus_wr & hit_slot_dur & lanes01;
  assign wr_cyc_start = bus_wr & hit_cyc_start & lanes01;
  assign wr_cyc_end = bus_wr & hit_cyc_end & lanes01;

  // =====================================================================
  // read mux; anything not decoded reads zero
  always @* begin
    next_rdata = 32'h0000_0000;
    gate_word = gate_open_o[gate_port*8 +: 8];
    if (hit_ctrl) begin
      next_rdata = {24'h000000, cyc_en};
    end else if (hit_status) begin
      next_rdata = {24'h000000, running};
    end else if (hit_slot_idx) begin
      next_rdata = {{22{1'b0}}, slot_idx};
    end else if (hit_slot_data) begin
      next_rdata = {{19{1'b0}}, slot_ports[slot_idx], slot_gates[slot_idx]};
    end else if (hit_slot_dur) begin
      next_rdata = {16'h0000, slot_dur[slot_idx]};
    end else if (hit_cyc_sel) begin
      next_rdata = {{29{1'b0}}, cyc_sel};
    end else if (hit_cyc_start) begin
      next_rdata = {{22{1'b0}}, cyc_start[cyc_sel]};
    end else if (hit_cyc_end) begin
      next_rdata = {{22{1'b0}}, cyc_end[cyc_sel]};
    end else if (hit_gate) begin
      next_rdata = {24'h000000, gate_word};
    end
  end

  // =====================================================================
  // tick divider: one-cycle enable every 200 ns
  always @(posedge clk_i) begin
    if (rst_i) begin
      tick_cnt <= {`TICK_CNT_W{1'b0}};
      tick <= 1'b0;
    end else if (tick_cnt == `TICK_DIV - 1) begin
      tick_cnt <= {`TICK_CNT_W{1'b0}};
      tick <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 1'b1;
      tick <= 1'b0;
    end
  end

  // =====================================================================
  // wishbone slave: one wait state, ack for one cycle, unmapped reads zero
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      cyc_en <= `CTRL_RST;
      slot_idx <= {`SLOT_AW{1'b0}};
      cyc_sel <= {`CYC_AW{1'b0}};
    end else begin
      wb_ack_o <= bus_req;
      if (bus_req)
        wb_dat_o <= next_rdata;
      if (wr_ctrl)
        cyc_en <= wb_dat_i[`CTRL_EN_LSB +: `CTRL_EN_W];
      if (wr_slot_idx)
        slot_idx <= wb_dat_i[`SLOT_AW-1:0];
      if (wr_cyc_sel)
        cyc_sel <= wb_dat_i[`CYC_AW-1:0];
    end
  end

  // =====================================================================
  // table writes; tables are not reset, software loads them before enabling
  always @(posedge clk_i) begin
    if (wr_slot_data) begin
      slot_gates[slot_idx] <= wb_dat_i[`SLOT_GATES_LSB +: `NUM_GATES];
      slot_ports[slot_idx] <= wb_dat_i[`SLOT_PORTS_LSB +: `NUM_PORTS];
    end
    if (wr_slot_dur)
      slot_dur[dur_wr_idx] <= wb_dat_i[`DUR_W-1:0];
    if (wr_cyc_start)
      cyc_start[cyc_sel] <= wb_dat_i[`SLOT_AW-1:0];
    if (wr_cyc_end)
      cyc_end[cyc_sel] <= wb_dat_i[`SLOT_AW-1:0];
  end

  // =====================================================================
  // successor of each cycle's current slot: index plus one, or the start
  // once the end slot is reached; the slot table itself holds no links
  genvar n;
  generate
    for (n = 0; n < `NUM_CYCLES; n = n + 1) begin : cyc_next
      assign next_slot[n] = (cur_slot[n] == cyc_end[n]) ?
        cyc_start[n] :
        cur_slot[n] + 1'b1;
    end
  endgenerate

  // =====================================================================
  // cycle engines: each steps through its own slots independently
  genvar g;
  generate
    for (g = 0; g < `NUM_CYCLES; g = g + 1) begin : cyc_eng
      always @(posedge clk_i) begin
        if (rst_i) begin
          running[g] <= 1'b0;
          fire[g] <= 1'b0;
          cur_slot[g] <= {`SLOT_AW{1'b0}};
          remain[g] <= {`DUR_W{1'b0}};
        end else begin
          fire[g] <= 1'b0;
          if (!cyc_en[g]) begin
            running[g] <= 1'b0;
          end else if (tick) begin
            if (!running[g]) begin
              running[g] <= 1'b1;
              cur_slot[g] <= cyc_start[g];
              remain[g] <= slot_dur[cyc_start[g]];
              fire[g] <= 1'b1;
            end else if (remain[g] <= `DUR_LAST) begin
              cur_slot[g] <= next_slot[g];
              remain[g] <= slot_dur[next_slot[g]];
              fire[g] <= 1'b1;
            end else begin
              remain[g] <= remain[g] - 1'b1;
            end
          end
        end
      end
    end
  endgenerate

  // =====================================================================
  // gate state: a firing slot overwrites the gates of the ports it names;
  // if two cycles fire together the higher cycle wins (software must avoid)
  always @(posedge clk_i) begin
    if (rst_i) begin
      gate_open_o <= 40'h00_0000_0000;
    end else begin
      for (c = 0; c < `NUM_CYCLES; c = c + 1) begin
        if (fire[c]) begin
          for (p = 0; p < `NUM_PORTS; p = p + 1) begin
            if (slot_ports[cur_slot[c]][p])
              gate_open_o[p*8 +: 8] <= slot_gates[cur_slot[c]];
          end
        end
      end
    end
  end

  // =====================================================================
  // per-port strict priority selection
  genvar k;
  generate
    for (k = 0; k < `NUM_PORTS; k = k + 1) begin : port_sel
      strict_prio_sel u_sel (
        .nonempty_i(queue_nonempty_i[k*8 +: 8]),
        .gate_open_i(gate_open_o[k*8 +: 8]),
        .sel_valid_o(tx_valid_o[k]),
        .sel_queue_o(tx_queue_o[k*3 +: 3])
      );
    end
  endgenerate

endmodule

// ==== rtl/gate_sched_map.vh ====
// register map, field layout and timing constants of the egress gate scheduler
`ifndef GATE_SCHED_MAP_VH
`define GATE_SCHED_MAP_VH

// =====================================================================
// geometry
`define NUM_PORTS 5
`define NUM_GATES 8
`define NUM_CYCLES 8
`define SLOT_DEPTH 1024
`define SLOT_AW 10
`define CYC_AW 3
`define DUR_W 16
`define DUR_LAST 16'h0001

// =====================================================================
// timing: clock 100 ns, tick 200 ns
`define CLK_PERIOD_NS 100
`define TICK_PERIOD_NS 200
`define TICK_DIV ((`TICK_PERIOD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define TICK_CNT_W 4

// =====================================================================
// register byte addresses
`define REG_CTRL 12'h000
`define REG_STATUS 12'h004
`define REG_SLOT_IDX 12'h008
`define REG_SLOT_DATA 12'h00c
`define REG_SLOT_DUR 12'h010
`define REG_CYC_SEL 12'h014
`define REG_CYC_START 12'h018
`define REG_CYC_END 12'h01c
`define REG_GATE_BASE 12'h020
`define REG_GATE_LAST 12'h030

// =====================================================================
// fields
`define CTRL_EN_LSB 0
`define CTRL_EN_W 8
`define SLOT_GATES_LSB 0
`define SLOT_PORTS_LSB 8
`define SLOT_IDX_MASK 32'h0000_03ff
`define CTRL_RST 8'h00

`endif

// ==== rtl/strict_prio_sel.v ====
// strict priority pick among open, non-empty egress queues of one port
`timescale 1ns/100ps
module strict_prio_sel (
  input wire [7:0] nonempty_i,
  input wire [7:0] gate_open_i,
  output reg sel_valid_o,
  output reg [2:0] sel_queue_o
);
  integer q;
  reg [7:0] eligible;

  // =====================================================================
  // highest eligible queue wins; loop runs upward so last hit is highest
  always @* begin
    eligible = nonempty_i & gate_open_i;
    sel_valid_o = 1'b0;
    sel_queue_o = 3'h0;
    for (q = 0; q < 8; q = q + 1) begin
      if (eligible[q]) begin
        sel_valid_o = 1'b1;
        sel_queue_o = q[2:0];
      end
    end
  end
endmodule

// ==== verif/gate_sched_properties.sv ====
// checker for the gate scheduler ports
`timescale 1ns/100ps
module gate_sched_properties (
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_ack_o,
  input wire [39:0] queue_nonempty_i,
  input wire [39:0] gate_open_o,
  input wire [4:0] tx_valid_o,
  input wire [14:0] tx_queue_o
);
  // ==========
  // bus and pacing
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held too long");
  ack_latency_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  ack_cause_a: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  // ticks come every second clock, so gates never move twice in a row
  gate_pace_a: assert property ($changed(gate_open_o) |=> $stable(gate_open_o))
    else $error("gates changed off tick");
  reset_closed_a: assert property (disable iff (1'b0) rst_i |=> gate_open_o == 40'h0)
    else $error("gates open after reset");
  // ==========
  // per port queue choice
  genvar p;
  generate
    for (p = 0; p < 5; p = p + 1) begin : g_port
      valid_gated_a: assert property (tx_valid_o[p] == |(gate_open_o[8*p+:8] & queue_nonempty_i[8*p+:8]))
        else $error("tx valid mismatch");
      prio_pick_a: assert property (tx_valid_o[p] |->
        ((gate_open_o[8*p+:8] & queue_nonempty_i[8*p+:8]) >> tx_queue_o[3*p+:3]) == 8'h01)
        else $error("not highest open queue");
      idle_zero_a: assert property (!tx_valid_o[p] |-> tx_queue_o[3*p+:3] == 3'h0)
        else $error("queue nonzero when idle");
    end
  endgenerate
endmodule
bind gate_scheduler gate_sched_properties gate_sched_properties_inst (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .queue_nonempty_i(queue_nonempty_i),
  .gate_open_o(gate_open_o), .tx_valid_o(tx_valid_o), .tx_queue_o(tx_queue_o));

// ==== verif/egress_queue_model.sv ====
// frame counters standing in for the egress queues
`timescale 1ns/100ps
module egress_queue_model (
  input wire clk_i,
  input wire rst_i,
  input wire hold_i,
  input wire [4:0] tx_valid_i,
  input wire [14:0] tx_queue_i,
  output wire [39:0] queue_nonempty_o
);
  reg [7:0] depth [0:39];
  integer i;
  genvar g;
  // ==========
  // occupancy flags
  generate
    for (g = 0; g < 40; g = g + 1) begin : g_ne
      assign queue_nonempty_o[g] = depth[g] != 8'h00;
    end
  endgenerate
  // filled only while held, so no race with the dequeue process
  task push(input integer q, input [7:0] n);
    depth[q] = depth[q] + n;
  endtask
  // one frame a clock leaves the chosen open queue; hold_i stalls the wire
  always @(posedge clk_i) begin
    for (i = 0; i < 40; i = i + 1) begin
      if (rst_i) depth[i] <= 8'h00;
    end
    for (i = 0; i < 5; i = i + 1) begin
      if (!rst_i && !hold_i && tx_valid_i[i]) depth[i*8+tx_queue_i[i*3+:3]] <= depth[i*8+tx_queue_i[i*3+:3]] - 8'h01;
    end
  end
endmodule

// ==== verif/tb.sv ====
// self-checking bench of the gate scheduler
`timescale 1ns/100ps
`include "gate_sched_map.vh"
`define CHK(nm, e, g) begin n_tests = n_tests + 1; if ((g) !== (e)) begin n_fail = n_fail + 1; $display("BAD %s exp %h got %h", nm, e, g); end end
module tb;
  reg clk_i = 1'b0;
  reg rst_i = 1'b1;
  reg wb_cyc_i = 1'b0;
  reg wb_stb_i = 1'b0;
  reg wb_we_i = 1'b0;
  reg [11:0] wb_adr_i = 12'h000;
  reg [3:0] wb_sel_i = 4'h0;
  reg [31:0] wb_dat_i = 32'h0;
  reg hold = 1'b1;
  reg [31:0] rd;
  wire [31:0] wb_dat_o;
  wire wb_ack_o;
  wire [39:0] queue_nonempty_i;
  wire [39:0] gate_open_o;
  wire [4:0] tx_valid_o;
  wire [14:0] tx_queue_o;
  integer n_fail = 0;
  integer n_tests = 0;
  // ==========
  // clock and parts
  always #50 clk_i = ~clk_i;
  gate_scheduler gate_scheduler_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .queue_nonempty_i(queue_nonempty_i), .gate_open_o(gate_open_o),
    .tx_valid_o(tx_valid_o), .tx_queue_o(tx_queue_o));
  egress_queue_model egress_queue_model_inst (.clk_i(clk_i), .rst_i(rst_i), .hold_i(hold),
    .tx_valid_i(tx_valid_o), .tx_queue_i(tx_queue_o), .queue_nonempty_o(queue_nonempty_i));
  // ==========
  // helpers
  task wrap_up;
    $display("tests %0d fails %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // single classic cycle, held until ack is sampled
  task wb(input we, input [11:0] a, input [31:0] d);
    integer n;
    wb_cyc_i <= 1'b1; wb_stb_i <= 1'b1; wb_we_i <= we; wb_adr_i <= a; wb_dat_i <= d; wb_sel_i <= 4'hf;
    n = 0;
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1 && n < 20) begin @(posedge clk_i); n = n + 1; end
    `CHK("ack", 1'b1, wb_ack_o)
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0; wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task slot(input [9:0] i, input [7:0] gt, input [4:0] pt, input [15:0] dur);
    wb(1'b1, `REG_SLOT_IDX, {22'h0, i});
    wb(1'b1, `REG_SLOT_DATA, {19'h0, pt, gt});
    wb(1'b1, `REG_SLOT_DUR, {16'h0, dur});
  endtask
  task wait_gate(input [7:0] e);
    integer n;
    n = 0;
    while (gate_open_o[7:0] !== e && n < 200) begin @(posedge clk_i); n = n + 1; end
  endtask
  // counts the clocks a port 0 gate set stands
  task dwell(input [7:0] e, input integer clks);
    integer n;
    wait_gate(e);
    n = 0;
    while (gate_open_o[7:0] === e && n < 200) begin @(posedge clk_i); n = n + 1; end
    `CHK("dwell", clks, n)
  endtask
  // ==========
  // scenarios
  task t_regs;
    wb(1'b1, `REG_SLOT_IDX, 32'hffff_ffff);
    wb(1'b0, `REG_SLOT_IDX, 32'h0);
    `CHK("slot_idx", 32'h0000_03ff, rd)
    wb(1'b0, 12'h040, 32'h0);
    `CHK("unmapped", 32'h0, rd)
    $display("t_regs done");
  endtask
  task t_prio;
    wait_gate(8'h81);
    `CHK("q_hi", 3'h7, tx_queue_o[2:0])
    wait_gate(8'h24);
    `CHK("q_mid", 3'h2, tx_queue_o[2:0])
    `CHK("port1", 8'h81, gate_open_o[15:8])
    hold <= 1'b0;
    repeat (3) @(posedge clk_i);
    `CHK("drain", 8'h8b, queue_nonempty_i[7:0])
    `CHK("idle", 1'b0, tx_valid_o[0])
    wb(1'b0, `REG_GATE_BASE, 32'h0);
    `CHK("gate_reg0", 8'h24, rd[7:0])
    wb(1'b0, `REG_GATE_BASE + 12'h004, 32'h0);
    `CHK("gate_reg1", 8'h81, rd[7:0])
    $display("t_prio done");
  endtask
  task t_sched;
    dwell(8'h81, 4);
    dwell(8'h24, 40);
    dwell(8'h00, 6);
    dwell(8'h81, 4);
    $display("t_sched done");
  endtask
  // ==========
  // main sequence and watchdog
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    egress_queue_model_inst.push(0, 8'h01);
    egress_queue_model_inst.push(1, 8'h01);
    egress_queue_model_inst.push(2, 8'h01);
    egress_queue_model_inst.push(3, 8'h01);
    egress_queue_model_inst.push(7, 8'h01);
    t_regs;
    slot(10'h3fc, 8'h81, 5'h1f, 16'h2);
    slot(10'h3fd, 8'h24, 5'h01, 16'h14);
    slot(10'h3fe, 8'h00, 5'h1f, 16'h3);
    wb(1'b1, `REG_CYC_SEL, 32'h0);
    wb(1'b1, `REG_CYC_START, 32'h3fc);
    wb(1'b1, `REG_CYC_END, 32'h3fe);
    wb(1'b1, `REG_CTRL, 32'h1);
    wb(1'b0, `REG_STATUS, 32'h0);
    `CHK("running", 8'h01, rd[7:0])
    t_prio;
    t_sched;
    wrap_up;
  end
  // far beyond the few hundred clocks the run needs
  initial begin
    #(100 * 3000);
    n_fail = n_fail + 1;
    wrap_up;
  end
endmodule
